/* File: hdl/mior_flash_read.sv */
// Behaviour
// - 6Bh takes 3 or 4 address bytes by extended bit; 6Ch always four.
// - Quad-output read returns one nibble per clock, changed on falling edges.
// - Quad-output dummy cycles ignore all four data lines.
// - Any byte start address; address steps by one per byte output.
// - After the top array address the counter wraps to zero, no break.
// - Four-line operation only while quad-enable is set.
// - BBh takes 3 or 4 address bytes by extended bit; BCh always four.
// - Dual read address arrives two bits per rising edge on lines 0,1.
// - High-performance table: no mode cycles, always full instruction first.
// - Enhanced table: instruction, address, four mode cycles, then latency.
// - Mode Axh: next frame starts directly with address.
// - Only the upper mode nibble matters; lower nibble ignored.
// - Other mode value: continuous mode ends when chip select rises.
// - Frame of eight clocks or fewer without instruction ends continuous mode.
// - Dual read returns two bits per clock on lines 0,1, on falling edges.
// - Dual dummy count follows latency code; lines ignored meanwhile.
// - Dummy counted falling to falling; zero dummy drives on that same edge.
// - Chip select high ends any read in data phase.
// - Extended-address bit makes 3-byte opcodes take four address bytes.
`timescale 1ns/1ps

module mior_flash_read
  import mior_pkg::*;
#(
  parameter logic [3:0][3:0] DUMMY_TABLE = DUMMY_TABLE_DEFAULT
)
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  // Serial pins
  input  wire logic        sck,
  input  wire logic        csN,
  input  wire logic [3:0]  ioIn,
  output      logic [3:0]  ioOut,
  output      logic [3:0]  ioOe,
  // Configuration
  input  wire logic        quadEnable,
  input  wire logic        extendedAddressEnable,
  input  wire logic [1:0]  latencyCode,
  input  wire logic        enhancedLatencyTable,
  // Status
  output      logic        executeInPlace,
  // Array port, data valid the cycle after memRdEn
  output      logic        memRdEn,
  output      logic [31:0] memAddr,
  input  wire logic [7:0]  memRdData
);

  typedef struct packed {
    mior_state_t state;
    logic [2:0]  sckS;
    logic [2:0]  csS;
    logic [3:0]  ioSa;
    logic [3:0]  ioSb;
    logic [3:0]  ioSc;
    logic        sckLvl;
    logic        csLvl;
    logic [5:0]  bitCnt;
    logic [3:0]  frameCnt;
    logic [7:0]  cmd;
    logic [31:0] addr;
    logic        wide;
    logic        dual;
    logic [7:0]  mode;
    logic        modeSeen;
    logic        execute_in_place;
    logic [3:0]  dummyCnt;
    logic [7:0]  shift;
    logic [1:0]  unitCnt;
    logic [3:0]  ioOut;
    logic [3:0]  ioOe;
    logic        fetchOn;
    logic        memRdEn;
    logic        rspPend;
    logic [31:0] memAddr;
  } mior_core_t;

  mior_core_t q;
  mior_core_t d;
  logic       sckRise;
  logic       sckFall;
  logic       csFall;
  logic       csRise;
  logic       bufInReady;
  logic       bufOutValid;
  logic [7:0] bufOutData;
  logic       bufPush;
  logic       bufPop;
  logic       bufFlush;
  logic [7:0] src;
  logic [7:0] cmdNext;
  logic [5:0] addrLast;

  // ----------------------------------------------------------------
  // Two-entry buffer between array and serializer
  // ----------------------------------------------------------------
  // A full buffer stalls the fetcher, never drops a byte
  mior_pair_fifo #(
    .WIDTH (8)
  ) u_buf (
    .mclk     (mclk),
    .sys_rst  (sys_rst),
    .flush    (bufFlush),
    .inValid  (bufPush),
    .inReady  (bufInReady),
    .inData   (memRdData),
    .outValid (bufOutValid),
    .outReady (bufPop),
    .outData  (bufOutData)
  );

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    d        = q;
    bufPop   = 1'b0;
    src      = 8'h00;
    cmdNext  = {q.cmd[6:0], q.ioSc[0]};
    addrLast = q.dual ? (q.wide ? ADDR4_DUAL_LAST : ADDR3_DUAL_LAST)
                      : (q.wide ? ADDR4_SERIAL_LAST : ADDR3_SERIAL_LAST);

    // Pin synchronisers; a level counts once stages two and three agree
    d.sckS = {q.sckS[1:0], sck};
    d.csS  = {q.csS[1:0], csN};
    d.ioSa = ioIn;
    d.ioSb = q.ioSa;
    d.ioSc = q.ioSb;
    d.sckLvl = (q.sckS[1] == q.sckS[2]) ? q.sckS[2] : q.sckLvl;
    d.csLvl  = (q.csS[1] == q.csS[2]) ? q.csS[2] : q.csLvl;
    sckRise = !q.sckLvl && d.sckLvl;
    sckFall = q.sckLvl && !d.sckLvl;
    csFall  = q.csLvl && !d.csLvl;
    csRise  = !q.csLvl && d.csLvl;

    // Array fetcher: one read in flight, only while the buffer has room
    bufPush   = q.rspPend && q.fetchOn;
    bufFlush  = csFall || csRise;
    d.rspPend = q.memRdEn;
    d.memRdEn = q.fetchOn && !q.memRdEn && !q.rspPend && bufInReady && !bufFlush;
    d.memAddr = (q.memAddr + 32'(q.memRdEn)) & ARRAY_ADDR_MASK;

    if (csFall)
    begin
      d.bitCnt   = '0;
      d.frameCnt = '0;
      d.modeSeen = 1'b0;
      d.addr     = ADDR_RESET;
      d.fetchOn  = 1'b0;
      d.unitCnt  = '0;
      d.state = q.execute_in_place ? S_ADDR : S_CMD;
    end
    else if (csRise)
    begin
      d.state   = S_IDLE;
      d.ioOe    = IO_RESET;
      d.fetchOn = 1'b0;
      d.memRdEn = 1'b0;
      if (q.modeSeen)
      begin
        d.execute_in_place = (q.mode[7:4] == MODE_KEEP_NIBBLE);
      end
      else if (q.frameCnt <= SHORT_FRAME_EDGES)
      begin
        d.execute_in_place = 1'b0;
      end
    end
    else if (!q.csLvl && sckRise)
    begin
      // Saturates, so a long frame never looks short
      d.frameCnt = q.frameCnt + 4'(q.frameCnt != FRAME_CNT_MAX);
      d.bitCnt = q.bitCnt + 6'h1;
      case (q.state)
        S_CMD:
        begin
          d.cmd = cmdNext;
          if (q.bitCnt == CMD_LAST)
          begin
            d.bitCnt = '0;
            d.state  = S_ADDR;
            case (cmdNext)
              QUAD_OUTPUT_READ_CMD:           {d.dual, d.wide} = {1'b0, extendedAddressEnable};
              QUAD_OUTPUT_READ_WIDE_ADDR_CMD: {d.dual, d.wide} = 2'h1;
              DUAL_INOUT_READ_CMD:            {d.dual, d.wide} = {1'b1, extendedAddressEnable};
              DUAL_INOUT_READ_WIDE_ADDR_CMD:  {d.dual, d.wide} = 2'h3;
              default:                        d.state = S_SKIP;
            endcase
            if (!d.dual && !quadEnable)
            begin
              d.state = S_SKIP;
            end
          end
        end
        S_ADDR:
        begin
          // two bits per rising edge in dual read
          d.addr = q.dual ? {q.addr[29:0], q.ioSc[1:0]} : {q.addr[30:0], q.ioSc[0]};
          if (q.bitCnt == addrLast)
          begin
            d.bitCnt = '0;
            // mode cycles only with the enhanced table
            d.state = (q.dual && enhancedLatencyTable) ? S_MODE : S_DUMMY;
            d.memAddr  = d.addr & ARRAY_ADDR_MASK;
            d.fetchOn  = 1'b1;
            d.dummyCnt = DUMMY_TABLE[latencyCode];
          end
        end
        S_MODE:
        begin
          d.mode = {q.mode[5:0], q.ioSc[1:0]};
          if (q.bitCnt == MODE_LAST)
          begin
            d.modeSeen = 1'b1;
            d.state    = S_DUMMY;
          end
        end
        default:
        begin
          // lines ignored in dummy and data phases
          d.bitCnt = q.bitCnt;
        end
      endcase
    end
    else if (!q.csLvl && sckFall && (q.state == S_DUMMY || q.state == S_DATA))
    begin
      if (q.state == S_DUMMY && q.dummyCnt != 4'h0)
      begin
        d.dummyCnt = q.dummyCnt - 4'h1;
      end
      else
      begin
        // Underrun shows all ones; keep the serial clock slow enough
        bufPop  = (q.unitCnt == 2'h0);
        src     = bufPop ? (bufOutValid ? bufOutData : 8'hff) : q.shift;
        d.state = S_DATA;
        if (q.dual)
        begin
          d.ioOut   = {2'h0, src[7:6]};
          d.shift   = {src[5:0], 2'h0};
          d.ioOe    = DUAL_OE;
          d.unitCnt = bufPop ? DUAL_UNITS_END : q.unitCnt - 2'h1;
        end
        else
        begin
          d.ioOut   = src[7:4];
          d.shift   = {src[3:0], 4'h0};
          d.ioOe    = QUAD_OE;
          d.unitCnt = bufPop ? QUAD_UNITS_END : q.unitCnt - 2'h1;
        end
      end
    end
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      q        <= '0;
      q.sckS   <= 3'h0;
      q.csS    <= 3'h7;
      q.csLvl  <= 1'b1;
      q.state  <= S_IDLE;
    end
    else
    begin
      q <= d;
    end
  end

  assign ioOut          = q.ioOut;
  assign ioOe           = q.ioOe;
  assign executeInPlace = q.execute_in_place;
  assign memRdEn        = q.memRdEn;
  assign memAddr        = q.memAddr;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_cs_high_quiet: assert property (@(posedge mclk) disable iff (sys_rst)
    q.csLvl |-> (q.ioOe == 4'h0))
    else $error("data lines driven while chip select is high");
  a_quad_needs_qe: assert property (@(posedge mclk) disable iff (sys_rst)
    (q.ioOe == QUAD_OE) |-> (!q.dual && quadEnable))
    else $error("four lines driven without quad enable");
  a_dual_two_lines: assert property (@(posedge mclk) disable iff (sys_rst)
    (q.state == S_DATA && q.dual) |-> (q.ioOe == DUAL_OE && q.ioOut[3:2] == 2'h0))
    else $error("dual read drives wrong lines");
  a_out_on_fall: assert property (@(posedge mclk) disable iff (sys_rst)
    $changed(q.ioOut) |-> $past(sckFall))
    else $error("data changed away from a falling edge");
  a_dummy_hiz: assert property (@(posedge mclk) disable iff (sys_rst)
    (q.state == S_DUMMY) |-> (q.ioOe == 4'h0))
    else $error("lines driven during dummy cycles");
  a_zero_dummy: assert property (@(posedge mclk) disable iff (sys_rst)
    (q.state == S_DUMMY && q.dummyCnt == 4'h0 && sckFall && !csRise)
      |=> (q.state == S_DATA && q.ioOe != 4'h0))
    else $error("data not driven on the falling edge ending latency");
  a_addr_wrap: assert property (@(posedge mclk) disable iff (sys_rst)
    (q.memRdEn && q.memAddr == ARRAY_ADDR_MASK) |=> (q.memAddr == 32'h0))
    else $error("read address failed to wrap to zero");
  a_mode_keep: assert property (@(posedge mclk) disable iff (sys_rst)
    (csRise && q.modeSeen && q.mode[7:4] == MODE_KEEP_NIBBLE) |=> q.execute_in_place ##1 q.execute_in_place)
    else $error("continuous mode lost after Axh");
  a_mode_leave: assert property (@(posedge mclk) disable iff (sys_rst)
    (csRise && q.modeSeen && q.mode[7:4] != MODE_KEEP_NIBBLE) |=> !q.execute_in_place)
    else $error("continuous mode kept after other mode value");
  a_short_exit: assert property (@(posedge mclk) disable iff (sys_rst)
    (csRise && !q.modeSeen && q.frameCnt <= SHORT_FRAME_EDGES) |=> !q.execute_in_place)
    else $error("short frame did not end continuous mode");
  a_xip_skips_cmd: assert property (@(posedge mclk) disable iff (sys_rst)
    (csFall && q.execute_in_place) |=> (q.state == S_ADDR && q.bitCnt == 6'h0))
    else $error("continuous frame did not start with address");

endmodule // mior_flash_read

/* File: pkg/mior_pkg.sv */
package mior_pkg;

  // ----------------------------------------------------------------
  // Opcodes and mode nibble
  // ----------------------------------------------------------------
  localparam logic [7:0] QUAD_OUTPUT_READ_CMD           = 8'h6b;
  localparam logic [7:0] QUAD_OUTPUT_READ_WIDE_ADDR_CMD = 8'h6c;
  localparam logic [7:0] DUAL_INOUT_READ_CMD            = 8'hbb;
  localparam logic [7:0] DUAL_INOUT_READ_WIDE_ADDR_CMD  = 8'hbc;
  localparam logic [3:0] MODE_KEEP_NIBBLE               = 4'ha;

  // ----------------------------------------------------------------
  // Array geometry
  // ----------------------------------------------------------------
  localparam logic [31:0] ARRAY_ADDR_MASK = 32'h01ff_ffff;
  localparam logic [31:0] ADDR_RESET      = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Rising-edge counts, last index of each phase
  // ----------------------------------------------------------------
  localparam logic [5:0] CMD_LAST          = 6'h07;
  localparam logic [5:0] ADDR3_SERIAL_LAST = 6'h17;
  localparam logic [5:0] ADDR4_SERIAL_LAST = 6'h1f;
  localparam logic [5:0] ADDR3_DUAL_LAST   = 6'h0b;
  localparam logic [5:0] ADDR4_DUAL_LAST   = 6'h0f;
  localparam logic [5:0] MODE_LAST         = 6'h03;
  localparam logic [3:0] SHORT_FRAME_EDGES = 4'h8;
  localparam logic [3:0] FRAME_CNT_MAX     = 4'hf;

  // ----------------------------------------------------------------
  // Output shaping
  // ----------------------------------------------------------------
  localparam logic [3:0] QUAD_OE        = 4'hf;
  localparam logic [3:0] DUAL_OE        = 4'h3;
  localparam logic [3:0] IO_RESET       = 4'h0;
  localparam logic [1:0] QUAD_UNITS_END = 2'h1;
  localparam logic [1:0] DUAL_UNITS_END = 2'h3;

  // Dummy cycles per latency code, entry index = code
  localparam logic [3:0][3:0] DUMMY_TABLE_DEFAULT = {4'h8, 4'h6, 4'h4, 4'h0};

  typedef enum logic [2:0] {
    S_IDLE,
    S_CMD,
    S_ADDR,
    S_MODE,
    S_DUMMY,
    S_DATA,
    S_SKIP
  } mior_state_t;

endpackage

/* File: hdl/mior_pair_fifo.sv */
`timescale 1ns/1ps

module mior_pair_fifo
  import mior_pkg::*;
#(
  parameter int WIDTH = 8
)
(
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             sys_rst,
  input  wire logic             flush,
  // Fill side
  input  wire logic             inValid,
  output      logic             inReady,
  input  wire logic [WIDTH-1:0] inData,
  // Drain side
  output      logic             outValid,
  input  wire logic             outReady,
  output      logic [WIDTH-1:0] outData
);

  typedef struct packed {
    logic [1:0][WIDTH-1:0] mem;
    logic [1:0]            count;
  } mior_fifo_t;

  mior_fifo_t q;
  mior_fifo_t d;
  logic       push;
  logic       pop;

  assign inReady  = (q.count != 2'h2);
  assign outValid = (q.count != 2'h0);
  assign outData  = q.mem[0];

  always_comb
  begin
    d    = q;
    push = inValid && inReady;
    pop  = outReady && outValid;
    if (pop)
    begin
      d.mem[0] = q.mem[1];
    end
    if (push)
    begin
      d.mem[q.count - 2'(pop)] = inData;
    end
    d.count = q.count + 2'(push) - 2'(pop);
    // Flush wins: a frame edge makes every held word stale
    if (flush)
    begin
      d.count = 2'h0;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

endmodule // mior_pair_fifo

/* File: tb/mior_host_model.sv */
`timescale 1ns/1ps

module mior_host_model
  import mior_pkg::*;
(
  // Clock
  input  wire logic       mclk,
  // Serial pins
  output      logic       sck,
  output      logic       csN,
  output      logic [3:0] ioIn,
  // Device drive
  input  wire logic [3:0] ioOut,
  input  wire logic [3:0] ioOe
);
  // Serial clock parks low between frames
  initial
  begin
    sck  = 1'b0;
    csN  = 1'b1;
    ioIn = 4'h0;
  end

  // ----------------------------------------------------------------
  // One serial clock
  // ----------------------------------------------------------------
  // Period of 12 mclk keeps the serial clock far below its ceiling
  // slow serial clock
  // Released lines flip so stale values never help
  // one fall per cycle
  task automatic cyc(input logic [7:0] d, output logic [7:0] seen);
    @(posedge mclk);
    sck  <= 1'b0;
    ioIn <= (d[3:0] & d[7:4]) | (~ioIn & ~d[7:4]);
    repeat (6) @(posedge mclk);
    seen = {ioOe, ioOut};
    sck  <= 1'b1;
    repeat (5) @(posedge mclk);
  endtask

  // ----------------------------------------------------------------
  // One frame: header lanes {enable, value}, then released cycles
  // ----------------------------------------------------------------
  // Header units are sent as given, high bits first
  // header, high first
  // Lines are released from the first dummy fall
  // release, select low
  task automatic run(input logic [7:0] hdr[$], input int nRel, output logic [7:0] got[$]);
    logic [7:0] s;
    got = {};
    @(posedge mclk);
    csN <= 1'b0;
    foreach (hdr[i]) cyc(hdr[i], s);
    repeat (nRel)
    begin
      cyc(8'h00, s);
      got.push_back(s);
    end
    @(posedge mclk);
    sck <= 1'b0;
    repeat (6) @(posedge mclk);
    csN <= 1'b1;
    repeat (8) @(posedge mclk);
  endtask
endmodule // mior_host_model

/* File: tb/mior_flash_read_tb.sv */
`timescale 1ns/1ps

`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
  $display("BAD t=%0t got %h exp %h", $time, (g), (e)); end end

module mior_flash_read_tb
  import mior_pkg::*;
;
  logic        mclk     = 1'b0;
  logic        sysRst   = 1'b1;
  logic        quadEn   = 1'b1;
  logic        extEn    = 1'b0;
  logic        enhTable = 1'b0;
  logic [1:0]  latCode  = 2'h0;
  logic [7:0]  memRdData = 8'h00;
  logic        sck, csN, execute_in_place, memRdEn;
  logic [3:0]  ioIn, ioOut, ioOe;
  logic [31:0] memAddr;
  logic [31:0] lfsrQ    = 32'h0001807f;
  int          fail_count, n_compared, cycles;

  always #12.5 mclk = ~mclk;

  mior_flash_read dut (
    .mclk(mclk), .sys_rst(sysRst), .sck(sck), .csN(csN), .ioIn(ioIn), .ioOut(ioOut),
    .ioOe(ioOe), .quadEnable(quadEn), .extendedAddressEnable(extEn),
    .latencyCode(latCode), .enhancedLatencyTable(enhTable), .executeInPlace(execute_in_place),
    .memRdEn(memRdEn), .memAddr(memAddr), .memRdData(memRdData)
  );

  mior_host_model host (
    .mclk(mclk), .sck(sck), .csN(csN), .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe)
  );

  // ----------------------------------------------------------------
  // Array model and helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] arr(input logic [31:0] a);
    return a[7:0] ^ a[15:8] ^ a[23:16] ^ {7'h00, a[24]} ^ 8'h3c;
  endfunction

  // Data valid only the cycle after a request, scrambled otherwise
  always @(posedge mclk)
    memRdData <= (memRdEn === 1'b1) ? arr(memAddr) : ~memRdData;

  function automatic logic [31:0] rnd();
    lfsrQ = {lfsrQ[30:0], lfsrQ[31] ^ lfsrQ[21] ^ lfsrQ[1] ^ lfsrQ[0]};
    return lfsrQ;
  endfunction

  task automatic tally_and_finish();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Hang guard, well above the expected run length
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 80000)
    begin
      fail_count++;
      tally_and_finish();
    end
  end

  // ----------------------------------------------------------------
  // One read frame with its expectations
  // ----------------------------------------------------------------
  task automatic readFrame(input logic [7:0] cmd, input logic [31:0] addr,
                           input logic [7:0] mode, input bit useCmd, input int nBytes);
    logic [7:0] hdr[$];
    logic [7:0] got[$];
    logic [7:0] byteV;
    logic [7:0] byteE;
    logic [3:0] oeE;
    bit         dual, wide, quadOk, isMode;
    int         aBits, dum, per, k;
    dual   = (cmd == DUAL_INOUT_READ_CMD) || (cmd == DUAL_INOUT_READ_WIDE_ADDR_CMD);
    wide   = extEn || (cmd == QUAD_OUTPUT_READ_WIDE_ADDR_CMD)
             || (cmd == DUAL_INOUT_READ_WIDE_ADDR_CMD);
    // unknown opcodes and quad reads without quad-enable stay silent
    quadOk = dual || (quadEn && (cmd == QUAD_OUTPUT_READ_CMD
                                 || cmd == QUAD_OUTPUT_READ_WIDE_ADDR_CMD));
    oeE    = quadOk ? (dual ? DUAL_OE : QUAD_OE) : IO_RESET;
    isMode = dual && enhTable;
    aBits  = wide ? 32 : 24;
    // Three-byte frames carry no upper address byte
    if (!wide)
      addr[31:24] = 8'h00;
    dum    = int'(DUMMY_TABLE_DEFAULT[latCode]);
    per    = dual ? 4 : 2;
    hdr    = {};
    if (useCmd)
      for (int i = 7; i >= 0; i--) hdr.push_back({7'h08, cmd[i]});
    for (int i = aBits - 1; i >= 0; i -= (dual ? 2 : 1))
      hdr.push_back(dual ? {6'h0c, addr[i -: 2]} : {7'h08, addr[i]});
    // Low mode nibble floats; the host may release it
    if (isMode)
      for (int i = 7; i >= 0; i -= 2) hdr.push_back(i > 3 ? {6'h0c, mode[i -: 2]} : 8'h00);
    host.run(hdr, dum + per * nBytes, got);
    if (dum > 0) `CHK(got[dum - 1][7:4], IO_RESET)
    for (int b = 0; b < nBytes; b++)
    begin
      byteV = 8'h00;
      for (int u = 0; u < per; u++)
      begin
        k = dum + b * per + u;
        byteV = dual ? {byteV[5:0], got[k][1:0]} : {byteV[3:0], got[k][3:0]};
        `CHK(got[k][7:4], oeE)
      end
      byteE = arr((addr + 32'(b)) & ARRAY_ADDR_MASK);
      if (quadOk) `CHK(byteV, byteE)
    end
    `CHK(ioOe, IO_RESET)
    `CHK(execute_in_place, isMode && mode[7:4] == MODE_KEEP_NIBBLE)
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic [7:0]  cmds[4];
    logic [7:0]  shortQ[$];
    logic [7:0]  junk[$];
    logic [31:0] r;
    logic [31:0] ad;
    logic [7:0]  opc;
    logic [7:0]  md;
    cmds   = '{QUAD_OUTPUT_READ_CMD, QUAD_OUTPUT_READ_WIDE_ADDR_CMD,
               DUAL_INOUT_READ_CMD, DUAL_INOUT_READ_WIDE_ADDR_CMD};
    shortQ = {8'h33, 8'h30, 8'h33, 8'h30, 8'h33};
    repeat (3) @(posedge mclk);
    sysRst <= 1'b0;
    repeat (4) @(posedge mclk);
    for (int t = 0; t < 24; t++)
    begin
      r = rnd();
      @(posedge mclk);
      quadEn   <= (t < 16) || r[0];
      extEn    <= r[1];
      latCode  <= r[3:2];
      enhTable <= r[4] || (t == 2);
      @(posedge mclk);
      // Top address on the wide opcode exercises the wrap
      ad  = (t == 3) ? ARRAY_ADDR_MASK : rnd();
      // An unknown opcode must leave the rest of its frame ignored
      opc = (t == 5) ? 8'h5a : cmds[t % 4];
      md  = (r[5] || t == 2) ? {MODE_KEEP_NIBBLE, r[11:8]} : r[15:8];
      readFrame(opc, ad, md, 1'b1, 3);
      if (execute_in_place === 1'b1)
      begin
        readFrame(opc, rnd(), r[6] ? 8'ha3 : 8'h3c, 1'b0, 2);
        if (execute_in_place === 1'b1)
        begin
          host.run(shortQ, 0, junk);
          `CHK(execute_in_place, 1'b0)
        end
      end
      $display("test %0d done: %0d compares, %0d bad", t, n_compared, fail_count);
    end
    tally_and_finish();
  end
endmodule // mior_flash_read_tb
